// *** include/sso_pkg.sv ***
package sso_pkg;
  // ****************************************************************
  // Opcode patterns
  // ****************************************************************
  localparam logic [15:0] SLEEP_OPCODE = 16'h0003;
  localparam logic [6:0] SET_ONES_TOP = 7'h15;
  localparam logic [7:0] LIT_MINUS_TOP = 8'hB2;
  localparam logic [6:0] FILE_MINUS_TOP = 7'h02;
  localparam logic [6:0] FILE_BORROW_TOP = 7'h01;
  // ****************************************************************
  // Values
  // ****************************************************************
  localparam logic [7:0] ALL_ONES = 8'hFF;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [1:0] PHASE_RESET = 2'h0;
  localparam logic [1:0] PHASE_READ = 2'h1;
  localparam logic [1:0] PHASE_CALC = 2'h2;
  localparam logic [1:0] PHASE_WRITE = 2'h3;
  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_SET_ALL_ONES_OP = 3'b001,
    OP_SLEEP = 3'b010,
    OP_LIT = 3'b011,
    OP_FSUB = 3'b100,
    OP_FSUBB = 3'b101
  } op_t;
endpackage : sso_pkg

// *** verilog/set_sleep_subtract_ops.sv ***
`timescale 1ns/1ps
module set_sleep_subtract_ops
  import sso_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [15:0] opcode,
  input wire logic [7:0] fileRdData,
  input wire logic wakeEvent,
  input wire logic wakeByWatchdog,
  output logic [7:0] fileAddr,
  output logic [7:0] fileWrData,
  output logic fileWrEn,
  output logic [7:0] workingAccumulator,
  output logic carryFlag,
  output logic zeroFlag,
  output logic overflowFlag,
  output logic digitCarryFlag,
  output logic timeoutFlagN,
  output logic powerdownFlagN,
  output logic watchdogClear,
  output logic sleeping,
  output logic [1:0] phase
);
  import sso_pkg::*;
  // ****************************************************************
  // Phase counter and decode
  // ****************************************************************
  logic [1:0] phase_r;
  logic sleep_r;
  logic wake1_r, wake2_r, wdt1_r, wdt2_r;
  op_t op;
  logic [7:0] operand_r, result_r;
  logic cOut_r, dcOut_r, ovOut_r;
  logic [8:0] diff;
  logic [4:0] low;
  logic [7:0] aOp, bOp;
  logic cin;

  // Wake inputs come from another domain, so synchronise them
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      wake1_r <= 1'b0;
      wake2_r <= 1'b0;
      wdt1_r <= 1'b0;
      wdt2_r <= 1'b0;
    end
    else
    begin
      wake1_r <= wakeEvent;
      wake2_r <= wake1_r;
      wdt1_r <= wakeByWatchdog;
      wdt2_r <= wdt1_r;
    end

  // Phases freeze while asleep, standing in for the stopped oscillator
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      phase_r <= PHASE_RESET;
    else if (!sleep_r)
      phase_r <= phase_r + 2'd1;

  always_comb
  begin
    op = OP_NONE;
    if (opcode == SLEEP_OPCODE)
      op = OP_SLEEP;
    else if (opcode[15:9] == SET_ONES_TOP)
      op = OP_SET_ALL_ONES_OP;
    else if (opcode[15:8] == LIT_MINUS_TOP)
      op = OP_LIT;
    else if (opcode[15:9] == FILE_MINUS_TOP)
      op = OP_FSUB;
    else if (opcode[15:9] == FILE_BORROW_TOP)
      op = OP_FSUBB;
  end

  // ****************************************************************
  // Datapath
  // ****************************************************************
  assign aOp = (op == OP_LIT) ? opcode[7:0] : operand_r;
  assign bOp = ~workingAccumulator;
  // Borrow subtract adds the carry, otherwise a plain +1
  assign cin = (op == OP_FSUBB) ? carryFlag : 1'b1;
  assign diff = {1'b0, aOp} + {1'b0, bOp} + {8'h00, cin};
  assign low = {1'b0, aOp[3:0]} + {1'b0, bOp[3:0]} + {4'h0, cin};

  // Operand read in phase two
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      operand_r <= ACC_RESET;
    else if (phase_r == PHASE_READ && !sleep_r)
      operand_r <= fileRdData;

  // Compute in phase three
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      result_r <= ACC_RESET;
      cOut_r <= 1'b0;
      dcOut_r <= 1'b0;
      ovOut_r <= 1'b0;
    end
    else if (phase_r == PHASE_CALC && !sleep_r)
    begin
      result_r <= (op == OP_SET_ALL_ONES_OP) ? ALL_ONES : diff[7:0];
      cOut_r <= diff[8];
      dcOut_r <= low[4];
      ovOut_r <= (aOp[7] == bOp[7]) && (diff[7] != aOp[7]);
    end

  // ****************************************************************
  // Write-back in phase four
  // ****************************************************************
  logic doWrite;
  logic isSub;
  assign doWrite = (phase_r == PHASE_WRITE) && !sleep_r;
  assign isSub = (op == OP_LIT) || (op == OP_FSUB) || (op == OP_FSUBB);

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      workingAccumulator <= ACC_RESET;
    else if (doWrite)
    begin
      if (op == OP_SET_ALL_ONES_OP && !opcode[8])
        workingAccumulator <= ALL_ONES;
      else if (op == OP_LIT)
        workingAccumulator <= result_r;
      else if ((op == OP_FSUB || op == OP_FSUBB) && !opcode[8])
        workingAccumulator <= result_r;
    end

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      carryFlag <= 1'b0;
      zeroFlag <= 1'b0;
      overflowFlag <= 1'b0;
      digitCarryFlag <= 1'b0;
    end
    else if (doWrite && isSub)
    begin
      carryFlag <= cOut_r;
      zeroFlag <= (result_r == 8'h00);
      overflowFlag <= ovOut_r;
      digitCarryFlag <= dcOut_r;
    end

  // File write strobe is combinational so it lines up with phase four
  assign fileAddr = opcode[7:0];
  assign fileWrData = result_r;
  assign fileWrEn = doWrite && ((op == OP_SET_ALL_ONES_OP) ||
    ((op == OP_FSUB || op == OP_FSUBB) && opcode[8]));

  // ****************************************************************
  // Sleep and status flags
  // ****************************************************************
  logic enterSleep;
  assign enterSleep = doWrite && (op == OP_SLEEP);

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      sleep_r <= 1'b0;
    else if (enterSleep)
      sleep_r <= 1'b1;
    else if (sleep_r && wake2_r)
      sleep_r <= 1'b0;

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      powerdownFlagN <= 1'b1;
      timeoutFlagN <= 1'b1;
    end
    else if (enterSleep)
    begin
      powerdownFlagN <= 1'b0;
      timeoutFlagN <= 1'b1;
    end
    else if (sleep_r && wake2_r && wdt2_r)
      timeoutFlagN <= 1'b0;

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      watchdogClear <= 1'b0;
    else
      watchdogClear <= enterSleep;

  assign sleeping = sleep_r;
  assign phase = phase_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_sleepFlags;
    @(posedge clk) disable iff (!nrst)
    enterSleep |=> !powerdownFlagN && timeoutFlagN && sleep_r;
  endproperty
  a_sleepFlags: assert property (p_sleepFlags)
    else $error("sleep flags wrong");

  property p_wdtClear;
    @(posedge clk) disable iff (!nrst)
    enterSleep |=> watchdogClear ##1 !watchdogClear;
  endproperty
  a_wdtClear: assert property (p_wdtClear)
    else $error("watchdog clear pulse wrong");

  property p_halt;
    @(posedge clk) disable iff (!nrst)
    (sleep_r && !wake2_r) |=> sleep_r && $stable(phase_r);
  endproperty
  a_halt: assert property (p_halt)
    else $error("core ran while asleep");

  property p_wdtWake;
    @(posedge clk) disable iff (!nrst)
    (sleep_r && wake2_r && wdt2_r) |=> !timeoutFlagN && !sleep_r;
  endproperty
  a_wdtWake: assert property (p_wdtWake)
    else $error("watchdog wake flag wrong");

  property p_setAcc;
    @(posedge clk) disable iff (!nrst)
    (doWrite && op == OP_SET_ALL_ONES_OP && !opcode[8])
      |=> workingAccumulator == ALL_ONES;
  endproperty
  a_setAcc: assert property (p_setAcc)
    else $error("set-all-ones accumulator wrong");

  property p_fileDest;
    @(posedge clk) disable iff (!nrst)
    (doWrite && (op == OP_FSUB || op == OP_FSUBB)) |-> fileWrEn == opcode[8];
  endproperty
  a_fileDest: assert property (p_fileDest)
    else $error("destination select wrong");

  property p_fileKeepsAcc;
    @(posedge clk) disable iff (!nrst)
    (doWrite && opcode[8] &&
      (op == OP_SET_ALL_ONES_OP || op == OP_FSUB || op == OP_FSUBB))
      |=> $stable(workingAccumulator);
  endproperty
  a_fileKeepsAcc: assert property (p_fileKeepsAcc)
    else $error("accumulator written for file destination");

  property p_zero;
    @(posedge clk) disable iff (!nrst)
    (doWrite && isSub) |=> zeroFlag == ($past(result_r) == 8'h00);
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero flag wrong");

  property p_litResult;
    @(posedge clk) disable iff (!nrst)
    (phase_r == PHASE_CALC && !sleep_r && op == OP_LIT && $stable(opcode))
      |=> result_r == 8'(opcode[7:0] - $past(workingAccumulator));
  endproperty
  a_litResult: assert property (p_litResult)
    else $error("literal subtract wrong");

  property p_phases;
    @(posedge clk) disable iff (!nrst)
    (phase_r == PHASE_READ && !sleep_r) |=> phase_r == PHASE_CALC;
  endproperty
  a_phases: assert property (p_phases)
    else $error("phase order wrong");
endmodule : set_sleep_subtract_ops

// *** bench/tb_set_sleep_subtract_ops.sv ***
`timescale 1ns/1ps
module tb_set_sleep_subtract_ops;
  import sso_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [15:0] opcode = 16'hFFFF;
  logic [7:0] fileRdData = 8'h00;
  logic wakeEvent = 1'b0;
  logic wakeByWatchdog = 1'b0;
  logic [7:0] fileAddr, fileWrData, workingAccumulator;
  logic fileWrEn, carryFlag, zeroFlag, overflowFlag, digitCarryFlag;
  logic timeoutFlagN, powerdownFlagN, watchdogClear, sleeping;
  logic [1:0] phase;
  logic [7:0] acc = 8'h00;
  logic [3:0] flg = 4'h0;
  logic wrSeen;
  logic [7:0] dataSeen;
  // Tail entries leave the accumulator off FFh before a file-only set
  // and run a borrow subtract with carry clear; the fourth entry reaches a zero result
  logic [23:0] tests [15] = '{24'h2A_10DA, 24'h2B_10DA, 24'hB2_0200,
    24'h04_1003, 24'h05_1101, 24'hB2_0100, 24'hB2_8000, 24'h03_1219,
    24'h02_121B, 24'hFF_FF00, 24'h2A_1000, 24'hB2_0200, 24'h2B_1000,
    24'hB2_0100, 24'h02_1205};
  int bad_count = 0;
  int check_count = 0;
  always #25 clk = ~clk;
  set_sleep_subtract_ops dut_u (.clk(clk), .nrst(nrst), .opcode(opcode),
    .fileRdData(fileRdData), .wakeEvent(wakeEvent),
    .wakeByWatchdog(wakeByWatchdog), .fileAddr(fileAddr),
    .fileWrData(fileWrData), .fileWrEn(fileWrEn),
    .workingAccumulator(workingAccumulator), .carryFlag(carryFlag),
    .zeroFlag(zeroFlag), .overflowFlag(overflowFlag),
    .digitCarryFlag(digitCarryFlag), .timeoutFlagN(timeoutFlagN),
    .powerdownFlagN(powerdownFlagN), .watchdogClear(watchdogClear),
    .sleeping(sleeping), .phase(phase));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test
  // Opcode goes back to an unused pattern so nothing repeats meanwhile
  task automatic exec(input logic [15:0] op, input logic [7:0] rd);
    int n;
    n = 0;
    @(negedge clk);
    while (phase !== PHASE_WRITE && n < 8)
    begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    opcode <= op;
    fileRdData <= rd;
    repeat (3) @(posedge clk);
    @(negedge clk);
    wrSeen = fileWrEn;
    dataSeen = fileWrData;
    chk(fileAddr, op[7:0]);
    chk({6'h00, phase}, {6'h00, PHASE_WRITE});
    @(posedge clk);
    opcode <= 16'hFFFF;
    @(negedge clk);
  endtask : exec
  task automatic run(input logic [15:0] op, input logic [7:0] f);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] a;
    logic cin;
    logic wrExp;
    logic isLit;
    isLit = op[15:8] == LIT_MINUS_TOP;
    a = isLit ? op[7:0] : f;
    cin = (op[15:9] == FILE_BORROW_TOP) ? flg[3] : 1'b1;
    s = {1'b0, a} + {1'b0, ~acc} + cin;
    h = {1'b0, a[3:0]} + {1'b0, ~acc[3:0]} + cin;
    wrExp = 1'b0;
    exec(op, f);
    if (op[15:9] == SET_ONES_TOP)
    begin
      wrExp = 1'b1;
      s = {1'b0, ALL_ONES};
      if (!op[8])
        acc = ALL_ONES;
    end
    else if (isLit || op[15:9] == FILE_MINUS_TOP ||
      op[15:9] == FILE_BORROW_TOP)
    begin
      flg = {s[8], s[7:0] == 8'h00, (a[7] != acc[7]) && (s[7] != a[7]), h[4]};
      wrExp = !isLit && op[8];
      if (!wrExp)
        acc = s[7:0];
    end
    chk({7'h00, wrSeen}, {7'h00, wrExp});
    if (wrExp)
      chk(dataSeen, s[7:0]);
    chk(workingAccumulator, acc);
    chk({4'h0, carryFlag, zeroFlag, overflowFlag, digitCarryFlag},
      {4'h0, flg});
  endtask : run
  // Wake latency is two synchroniser flops plus the state flop
  task automatic nap(input logic byDog);
    int n;
    logic [1:0] p;
    exec(SLEEP_OPCODE, 8'h00);
    chk({sleeping, powerdownFlagN, timeoutFlagN, watchdogClear},
      4'hB);
    p = phase;
    repeat (4) @(negedge clk);
    chk({5'h00, sleeping, phase}, {5'h00, 1'b1, p});
    chk({7'h00, watchdogClear}, 8'h00);
    @(posedge clk);
    wakeEvent <= 1'b1;
    wakeByWatchdog <= byDog;
    n = 0;
    while (sleeping !== 1'b0 && n < 8)
    begin
      @(negedge clk);
      n++;
    end
    chk(n[7:0], 8'h04);
    chk({7'h00, timeoutFlagN}, {7'h00, !byDog});
    @(posedge clk);
    wakeEvent <= 1'b0;
    wakeByWatchdog <= 1'b0;
  endtask : nap
  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial
  begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    chk(workingAccumulator, ACC_RESET);
    chk({6'h00, timeoutFlagN, powerdownFlagN}, 8'h03);
    for (int i = 0; i < 15; i++)
      run(tests[i][23:8], tests[i][7:0]);
    $display("test ops done");
    // Watchdog wake first, so the next sleep must raise the time-out flag
    nap(1'b1);
    nap(1'b0);
    run(16'hB255, 8'h00);
    $display("test sleep done");
    finish_test();
  end
  initial
  begin
    #(3000 * 50);
    bad_count++;
    finish_test();
  end
endmodule : tb_set_sleep_subtract_ops
